// file: rtl/cgc_consts.svh
// Purpose: constants of the clock generation control block
// Assumes: 50 MHz register clock
// Notes: offsets are byte addresses on the plain register port
`ifndef CGC_CONSTS_SVH
`define CGC_CONSTS_SVH

// ************************************************************
// register offsets
// ************************************************************
`define CGC_OFS_DIVCTL 8'h00
`define CGC_OFS_SRCSEL 8'h04
`define CGC_OFS_PLL 8'h08
`define CGC_OFS_PLL2 8'h0c
`define CGC_OFS_OSTD 8'h10
`define CGC_OFS_STATUS 8'h14
`define CGC_OFS_OSCCFG 8'h18

// ************************************************************
// field positions and reset values
// ************************************************************
`define CGC_DIVCTL_MASK 32'hffff_ff0f
`define CGC_DIVCTL_RST 32'h0000_0000
`define CGC_SRC_LSB 8
`define CGC_MUL_LSB 8
`define CGC_MUL_MIN 6'h07
`define CGC_MUL_MAX 6'h1e
`define CGC_MUL_RST 6'h07
`define CGC_OSTD_IE_BIT 7
`define CGC_SRC_LSO 3'h0
`define CGC_SRC_HSO 3'h1
`define CGC_SRC_MAIN 3'h2
`define CGC_SRC_SUB 3'h3
`define CGC_SRC_PLL 3'h4
`define CGC_LPT_LSO 2'h2
`define CGC_LPT_LSO_DIV 3'h4
`define CGC_LPT_LSO_HZ 1000000

// ************************************************************
// frequencies in kHz or Hz and timing
// ************************************************************
`define CGC_PLL_IN_MIN_KHZ 4000
`define CGC_PLL_IN_MAX_KHZ 12500
`define CGC_PLL_OUT_MIN_KHZ 24000
`define CGC_PLL_OUT_MAX_KHZ 64000
`define CGC_LSO_KHZ 4000
`define CGC_USB_KHZ 48000
`define CGC_WDT_OSC_HZ 15000
`define CGC_SUB_HZ 32768
`define CGC_CLK_PERIOD_NS 20
`define CGC_SWITCH_GAP_NS 100
`define CGC_SWITCH_GAP_CYC ((`CGC_SWITCH_GAP_NS + `CGC_CLK_PERIOD_NS - 1) / `CGC_CLK_PERIOD_NS)

`endif

// file: rtl/cgc_pkg.sv
// Purpose: types of the clock generation control block
// Assumes: nothing beyond the constants header
// Notes: states are one-hot
package cgc_pkg;

   // ************************************************************
   // types
   // ************************************************************
   // source switch sequencer
   typedef enum logic [2:0] {
      CGC_RUN = 3'b001,
      CGC_DROP = 3'b010,
      CGC_RAISE = 3'b100
   } cgc_fsm_e;

   // divider selects per clock consumer group
   typedef struct packed {
      logic [3:0] cpu_dma_dtc_mem_div; // system clock
      logic [3:0] canfd_ram_pwm_div; // fast peripheral clock
      logic [3:0] periph_div; // general peripheral clock
      logic [3:0] adc_div; // analog conversion clock
      logic [3:0] flash_div; // flash interface clock
   } cgc_route_s;

   // oscillator and pll configuration
   typedef struct packed {
      logic [1:0] hso_sel; // 24/32/48/64 MHz
      logic [1:0] lpt_sel; // low-power timer source
      logic [2:0] lpt_div; // low-power timer divide ratio
      logic [2:0] cac_sel; // frequency measure source
      logic [2:0] remc_sel; // remote receiver source
      logic [5:0] pll_mul;
      logic [1:0] pll_div;
      logic [5:0] pll2_mul;
      logic [1:0] pll2_div;
   } cgc_osc_cfg_s;

   // whole block state
   typedef struct packed {
      cgc_fsm_e fsm;
      logic [2:0] cur_src; // source now granted
      logic [3:0] wait_cnt;
      logic [31:0] divctl;
      logic [2:0] src_sel; // source requested by software
      cgc_osc_cfg_s osc;
      logic det_en;
      logic stop_ie;
      logic stop_flag;
      logic [1:0] stop_sync;
      logic stop_prev;
      logic [31:0] rdata;
   } cgc_state_s;

endpackage : cgc_pkg

// file: rtl/cgc_clock_ctrl.sv
// Purpose: clock generation control: source select, plls, dividers, stop detect
// Assumes: one register clock; oscillators and clock gates sit outside
// Notes: a source change drops every source enable for a gap before raising the new one
`timescale 1ns/100ps
`include "cgc_consts.svh"

module cgc_clock_ctrl #(
   parameter int MAIN_KHZ = 12000 // main oscillator frequency
) (
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   input wire logic main_osc_stop_i,
   output logic [4:0] src_en_o,
   output cgc_pkg::cgc_route_s route_o,
   output cgc_pkg::cgc_osc_cfg_s osc_cfg_o,
   output logic osc_stop_irq_o,
   output logic pwm_oe_stop_o,
   output logic pll_cfg_ok_o
);
   import cgc_pkg::*;

   // ************************************************************
   // state
   // ************************************************************
   cgc_state_s st; // registered state
   cgc_state_s next_st; // next state
   logic stop_edge; // new stop seen after sync
   logic src_legal; // written source code is legal
   logic mul_legal; // written pll multiplier legal
   logic mul2_legal; // written pll2 multiplier legal
   logic [31:0] pll_in_khz; // pll input after divider
   logic [31:0] pll_out_khz;
   logic [31:0] pll2_in_khz;
   logic [31:0] pll2_out_khz;
   logic [31:0] lpt_hz; // low-power timer clock rate
   logic usb_rate_ok; // second pll gives the usb clock rate

   // divide ratio from 2-bit code, 3 reads as 4
   function automatic logic [31:0] div_ratio(input logic [1:0] code);
      div_ratio = (code == 2'h0) ? 32'd1 : ((code == 2'h1) ? 32'd2 : 32'd4);
   endfunction : div_ratio

   // ************************************************************
   // pll frequency check
   // ************************************************************
   // multiplier is (code+1)/2, kept in half steps to stay exact
   always_comb begin
      pll_in_khz = MAIN_KHZ / div_ratio(st.osc.pll_div);
      pll_out_khz = (pll_in_khz * (32'(st.osc.pll_mul) + 32'd1)) / 32'd2;
      pll2_in_khz = MAIN_KHZ / div_ratio(st.osc.pll2_div);
      pll2_out_khz = (pll2_in_khz * (32'(st.osc.pll2_mul) + 32'd1)) / 32'd2;
   end

   // software is trusted to keep limits; this only reports them
   assign pll_cfg_ok_o = (pll_in_khz >= `CGC_PLL_IN_MIN_KHZ) &&
      (pll_in_khz <= `CGC_PLL_IN_MAX_KHZ) &&
      (pll2_in_khz >= `CGC_PLL_IN_MIN_KHZ) && (pll2_in_khz <= `CGC_PLL_IN_MAX_KHZ) &&
      (pll_out_khz >= `CGC_PLL_OUT_MIN_KHZ) && (pll_out_khz <= `CGC_PLL_OUT_MAX_KHZ) &&
      (pll2_out_khz >= `CGC_PLL_OUT_MIN_KHZ) && (pll2_out_khz <= `CGC_PLL_OUT_MAX_KHZ);

   // ************************************************************
   // derived clock rates
   // ************************************************************
   // low-power timer rate per source; code 0 sub, 1 watchdog, 2 low-speed
   always_comb begin
      unique case (st.osc.lpt_sel)
         2'h0: lpt_hz = `CGC_SUB_HZ;
         2'h1: lpt_hz = `CGC_WDT_OSC_HZ;
         default: lpt_hz = (`CGC_LSO_KHZ * 1000) / 32'(st.osc.lpt_div);
      endcase
   end

   // usb needs an exact rate, only the second pll output is checked for it
   assign usb_rate_ok = (pll2_out_khz == `CGC_USB_KHZ);

   // ************************************************************
   // write legality
   // ************************************************************
   always_comb begin
      src_legal = (wdata_i[`CGC_SRC_LSB +: 3] <= `CGC_SRC_PLL);
      mul_legal = (wdata_i[`CGC_MUL_LSB +: 6] >= `CGC_MUL_MIN) &&
         (wdata_i[`CGC_MUL_LSB +: 6] <= `CGC_MUL_MAX);
      mul2_legal = mul_legal;
   end

   // only the second sync stage is looked at
   assign stop_edge = st.stop_sync[1] & ~st.stop_prev & st.det_en;

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      next_st = st;
      // pin synchroniser
      next_st.stop_sync = {st.stop_sync[0], main_osc_stop_i};
      next_st.stop_prev = st.stop_sync[1];
      next_st.rdata = 32'h0000_0000;
      // register writes
      if (wr_i) begin
         unique case (addr_i)
            `CGC_OFS_DIVCTL: next_st.divctl = wdata_i & `CGC_DIVCTL_MASK;
            `CGC_OFS_SRCSEL: begin
               // illegal codes ignored; main and pll refused while main is dead
               if (src_legal && !(st.stop_flag &&
                  (wdata_i[`CGC_SRC_LSB +: 3] == `CGC_SRC_MAIN ||
                   wdata_i[`CGC_SRC_LSB +: 3] == `CGC_SRC_PLL))) begin
                  next_st.src_sel = wdata_i[`CGC_SRC_LSB +: 3];
               end
            end
            `CGC_OFS_PLL: begin
               next_st.osc.pll_div = wdata_i[1:0];
               if (mul_legal) begin
                  next_st.osc.pll_mul = wdata_i[`CGC_MUL_LSB +: 6];
               end
            end
            `CGC_OFS_PLL2: begin
               next_st.osc.pll2_div = wdata_i[1:0];
               if (mul2_legal) begin
                  next_st.osc.pll2_mul = wdata_i[`CGC_MUL_LSB +: 6];
               end
            end
            `CGC_OFS_OSTD: begin
               next_st.det_en = wdata_i[0];
               next_st.stop_ie = wdata_i[`CGC_OSTD_IE_BIT];
            end
            `CGC_OFS_STATUS: begin
               // write one clears; a new stop below wins
               if (wdata_i[0]) begin
                  next_st.stop_flag = 1'b0;
               end
            end
            `CGC_OFS_OSCCFG: begin
               next_st.osc.hso_sel = wdata_i[1:0];
               if (wdata_i[5:4] != 2'h3) begin
                  next_st.osc.lpt_sel = wdata_i[5:4];
               end
               if (wdata_i[10:8] <= 3'h5) begin
                  next_st.osc.cac_sel = wdata_i[10:8];
               end
               if (wdata_i[14:12] <= 3'h4) begin
                  next_st.osc.remc_sel = wdata_i[14:12];
               end
            end
            default: ; // unmapped writes dropped
         endcase
      end
      // low-power timer divides only the low-speed source by four
      next_st.osc.lpt_div = (next_st.osc.lpt_sel == `CGC_LPT_LSO) ?
         `CGC_LPT_LSO_DIV : 3'h1;
      // oscillation stop: fall back to the low-speed oscillator
      if (stop_edge) begin
         next_st.stop_flag = 1'b1;
         // stop wins over a source write landing in the same cycle
         if (st.src_sel == `CGC_SRC_MAIN || st.src_sel == `CGC_SRC_PLL ||
            next_st.src_sel == `CGC_SRC_MAIN || next_st.src_sel == `CGC_SRC_PLL) begin
            next_st.src_sel = `CGC_SRC_LSO;
         end
      end
      // register reads, data stand the next cycle only
      if (rd_i) begin
         unique case (addr_i)
            `CGC_OFS_DIVCTL: next_st.rdata = st.divctl;
            `CGC_OFS_SRCSEL: next_st.rdata = {21'h0, st.src_sel, 8'h00};
            `CGC_OFS_PLL: next_st.rdata = {18'h0, st.osc.pll_mul, 6'h00, st.osc.pll_div};
            `CGC_OFS_PLL2: next_st.rdata = {18'h0, st.osc.pll2_mul, 6'h00, st.osc.pll2_div};
            `CGC_OFS_OSTD: next_st.rdata = {24'h0, st.stop_ie, 6'h00, st.det_en};
            `CGC_OFS_STATUS: next_st.rdata = {21'h0, st.cur_src, 5'h00,
               pll_cfg_ok_o, (st.fsm != CGC_RUN), st.stop_flag};
            `CGC_OFS_OSCCFG: next_st.rdata = {17'h0, st.osc.remc_sel, 1'b0,
               st.osc.cac_sel, 2'h0, st.osc.lpt_sel, 2'h0, st.osc.hso_sel};
            default: next_st.rdata = 32'h0000_0000; // unmapped reads zero
         endcase
      end
      // glitch-free hand-over between sources
      unique case (st.fsm)
         CGC_RUN: begin
            if (st.src_sel != st.cur_src) begin
               next_st.fsm = CGC_DROP;
               next_st.wait_cnt = 4'(`CGC_SWITCH_GAP_CYC);
            end
         end
         CGC_DROP: begin
            // old enable is off; let its phase finish
            if (st.wait_cnt == 4'h1) begin
               next_st.fsm = CGC_RAISE;
               next_st.cur_src = st.src_sel;
            end else begin
               next_st.wait_cnt = st.wait_cnt - 4'h1;
            end
         end
         CGC_RAISE: next_st.fsm = CGC_RUN;
      endcase
   end

   // ************************************************************
   // state register
   // ************************************************************
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st <= '{fsm: CGC_RUN, cur_src: `CGC_SRC_LSO, wait_cnt: 4'h0,
            divctl: `CGC_DIVCTL_RST, src_sel: `CGC_SRC_LSO,
            osc: '{hso_sel: 2'h0, lpt_sel: 2'h0, lpt_div: 3'h1, cac_sel: 3'h0,
               remc_sel: 3'h0, pll_mul: `CGC_MUL_RST, pll_div: 2'h0,
               pll2_mul: `CGC_MUL_RST, pll2_div: 2'h0},
            det_en: 1'b0, stop_ie: 1'b0, stop_flag: 1'b0, stop_sync: 2'h0,
            stop_prev: 1'b0, rdata: 32'h0000_0000};
      end else begin
         st <= next_st;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   // a source enable is only high in RUN, so old and new never overlap
   assign src_en_o = (st.fsm == CGC_RUN) ? (5'h01 << st.cur_src) : 5'h00;
   assign rdata_o = st.rdata;
   assign route_o = '{cpu_dma_dtc_mem_div: st.divctl[27:24],
      canfd_ram_pwm_div: st.divctl[3:0], periph_div: st.divctl[11:8],
      adc_div: st.divctl[15:12], flash_div: st.divctl[31:28]};
   assign osc_cfg_o = st.osc;
   assign osc_stop_irq_o = st.stop_flag & st.stop_ie;
   assign pwm_oe_stop_o = st.stop_flag & st.stop_ie;

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!arst_n_i);

   a_src_onehot_gap: assert property ($onehot0(src_en_o))
      else $error("more than one source enable high");
   a_switch_gap_len: assert property (
      (st.fsm == CGC_RUN && st.src_sel != st.cur_src)
      |=> (src_en_o == 5'h00) [*5] ##1 (src_en_o == 5'h00) ##1 $onehot(src_en_o))
      else $error("switch gap length wrong");
   a_src_code_legal: assert property (st.src_sel <= `CGC_SRC_PLL)
      else $error("illegal source code held");
   a_mul_range: assert property (
      st.osc.pll_mul >= `CGC_MUL_MIN && st.osc.pll_mul <= `CGC_MUL_MAX &&
      st.osc.pll2_mul >= `CGC_MUL_MIN && st.osc.pll2_mul <= `CGC_MUL_MAX)
      else $error("pll multiplier out of range");
   a_stop_fallback: assert property (
      (stop_edge && (st.src_sel == `CGC_SRC_MAIN || st.src_sel == `CGC_SRC_PLL))
      |=> st.src_sel == `CGC_SRC_LSO && st.stop_flag)
      else $error("no fallback to low-speed oscillator");
   // a dead main oscillator must not be picked again until the flag is cleared
   a_dead_src_refused: assert property (
      (wr_i && addr_i == `CGC_OFS_SRCSEL && st.stop_flag &&
      wdata_i[`CGC_SRC_LSB +: 3] == `CGC_SRC_MAIN) |=> st.src_sel != `CGC_SRC_MAIN)
      else $error("dead main oscillator selected");
   a_stop_notify: assert property (
      (osc_stop_irq_o == (st.stop_flag && st.stop_ie)) &&
      (pwm_oe_stop_o == osc_stop_irq_o))
      else $error("stop notify not gated by enable");
   a_stop_set_wins: assert property (
      (stop_edge && wr_i && addr_i == `CGC_OFS_STATUS) |=> st.stop_flag)
      else $error("stop lost on clear");
   a_reserved_zero: assert property (
      (rd_i && addr_i == `CGC_OFS_DIVCTL) |=> rdata_o[7:4] == 4'h0)
      else $error("reserved divider bits not zero");
   a_fast_div_rd: assert property (
      (wr_i && addr_i == `CGC_OFS_DIVCTL)
      |=> route_o.canfd_ram_pwm_div == $past(wdata_i[3:0]))
      else $error("fast divider not taken");
   a_lpt_div: assert property (
      osc_cfg_o.lpt_div == ((osc_cfg_o.lpt_sel == `CGC_LPT_LSO) ? 3'h4 : 3'h1))
      else $error("low-power timer divide wrong");
   a_lpt_rate: assert property (
      (osc_cfg_o.lpt_sel == `CGC_LPT_LSO) |-> lpt_hz == `CGC_LPT_LSO_HZ)
      else $error("low-power timer rate wrong");

   c_switch_done: cover property (st.fsm == CGC_DROP ##6 st.fsm == CGC_RUN);
   c_stop_fallback: cover property (stop_edge && st.src_sel == `CGC_SRC_PLL);
   c_stop_irq: cover property (osc_stop_irq_o);
   c_pll_ok: cover property ($rose(pll_cfg_ok_o));
   c_usb_rate: cover property (usb_rate_ok);

endmodule : cgc_clock_ctrl

// file: testbench/testbench.sv
// Purpose: self-checking bench for the clock generation control block
// Assumes: 50 MHz clock, default main oscillator of 12000 kHz
// Notes: expected values come from the field codes, not from the design
`timescale 1ns/100ps
`include "cgc_consts.svh"

module testbench;
   import cgc_pkg::*;

   // ************************************************************
   // signals
   // ************************************************************
   logic ref_clk_i = 1'b0; // register clock
   logic arst_n_i = 1'b0; // reset, active low
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [31:0] rdata_o;
   logic main_osc_stop_i = 1'b0; // stop indication from the oscillator
   logic [4:0] src_en_o;
   cgc_route_s route_o;
   cgc_osc_cfg_s osc_cfg_o;
   logic osc_stop_irq_o;
   logic pwm_oe_stop_o;
   logic pll_cfg_ok_o;
   int err_count = 0; // mismatches seen
   int checks_done = 0; // comparisons made
   logic [31:0] rd_val; // last read result

   // clock of 20 ns period
   always #10 ref_clk_i = ~ref_clk_i;

   cgc_clock_ctrl u_cgc_clock_ctrl (
      .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .main_osc_stop_i(main_osc_stop_i),
      .src_en_o(src_en_o), .route_o(route_o), .osc_cfg_o(osc_cfg_o),
      .osc_stop_irq_o(osc_stop_irq_o), .pwm_oe_stop_o(pwm_oe_stop_o),
      .pll_cfg_ok_o(pll_cfg_ok_o)
   );

   // ************************************************************
   // shared tasks
   // ************************************************************
   // verdict and end of run, one place only
   task automatic stop_test();
      $display("checks %0d, errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : stop_test

   // compare seen against expected
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
   endtask : wr

   // one-cycle read strobe, data sampled in the following cycle
   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      #1;
      rd_val = rdata_o;
   endtask : rd

   // bounded wait for a given source enable pattern
   task automatic wait_src(input logic [4:0] exp);
      int n;
      for (n = 0; n < 20 && src_en_o !== exp; n++) begin
         @(posedge ref_clk_i);
         #1;
      end
      // a wait that ran out is a mismatch and ends the run
      if (src_en_o !== exp) begin
         chk({27'h0, src_en_o}, {27'h0, exp});
         stop_test();
      end
   endtask : wait_src

   // ************************************************************
   // scenarios
   // ************************************************************
   // values straight after reset
   task automatic t_reset();
      chk({27'h0, src_en_o}, 32'h1);
      chk({12'h0, route_o}, 32'h0);
      chk({26'h0, osc_cfg_o.pll_mul}, 32'h7);
      chk({31'h0, pll_cfg_ok_o}, 32'h1);
      chk({30'h0, osc_stop_irq_o, pwm_oe_stop_o}, 32'h0);
   endtask : t_reset

   // reserved divider bits read zero, fast peripheral field routed
   task automatic t_divctl();
      wr(`CGC_OFS_DIVCTL, 32'hffff_ffff);
      rd(`CGC_OFS_DIVCTL);
      chk(rd_val, 32'hffff_ff0f);
      chk({28'h0, route_o.canfd_ram_pwm_div}, 32'hf);
      // divider codes picked so every domain stays within its limit
      wr(`CGC_OFS_DIVCTL, 32'h1234_5607);
      #1;
      chk({28'h0, route_o.cpu_dma_dtc_mem_div}, 32'h2);
      chk({28'h0, route_o.canfd_ram_pwm_div}, 32'h7);
      chk({12'h0, route_o}, 32'h0002_7651);
      rd(8'h40);
      chk(rd_val, 32'h0);
   endtask : t_divctl

   // every source code, gap with all enables low, then one-hot
   task automatic t_source();
      logic [2:0] codes [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h0};
      foreach (codes[i]) begin
         wr(`CGC_OFS_SRCSEL, {21'h0, codes[i], 8'h00});
         repeat (4) @(posedge ref_clk_i);
         #1;
         chk({27'h0, src_en_o}, 32'h0);
         repeat (4) @(posedge ref_clk_i);
         #1;
         chk({27'h0, src_en_o}, 32'h1 << codes[i]);
         rd(`CGC_OFS_STATUS);
         chk({29'h0, rd_val[10:8]}, {29'h0, codes[i]});
      end
      wr(`CGC_OFS_SRCSEL, 32'h0000_0500);
      repeat (10) @(posedge ref_clk_i);
      #1;
      chk({27'h0, src_en_o}, 32'h1);
   endtask : t_source

   // pll multiplier range, input division and limits
   task automatic t_pll();
      wr(`CGC_OFS_PLL, 32'h0000_1e00);
      #1;
      chk({26'h0, osc_cfg_o.pll_mul}, 32'h1e);
      chk({31'h0, pll_cfg_ok_o}, 32'h0);
      wr(`CGC_OFS_PLL, 32'h0000_0600);
      #1;
      chk({26'h0, osc_cfg_o.pll_mul}, 32'h1e);
      wr(`CGC_OFS_PLL, 32'h0000_0f01);
      #1;
      chk({31'h0, pll_cfg_ok_o}, 32'h1);
      wr(`CGC_OFS_PLL, 32'h0000_0f02);
      #1;
      chk({31'h0, pll_cfg_ok_o}, 32'h0);
      wr(`CGC_OFS_PLL, 32'h0000_0f01);
      wr(`CGC_OFS_PLL2, 32'h0000_1f00);
      #1;
      chk({26'h0, osc_cfg_o.pll2_mul}, 32'h7);
      chk({31'h0, pll_cfg_ok_o}, 32'h1);
      wr(`CGC_OFS_PLL2, 32'h0000_1d01);
      rd(`CGC_OFS_STATUS);
      chk({31'h0, rd_val[2]}, 32'h0);
   endtask : t_pll

   // oscillator options and low-power timer source
   task automatic t_osccfg();
      wr(`CGC_OFS_OSCCFG, 32'h0000_0023);
      #1;
      chk({30'h0, osc_cfg_o.hso_sel}, 32'h3);
      chk({29'h0, osc_cfg_o.lpt_div}, 32'h4);
      wr(`CGC_OFS_OSCCFG, 32'h0000_0010);
      #1;
      chk({29'h0, osc_cfg_o.lpt_div}, 32'h1);
      // highest legal measure and remote codes, timer code 3 refused
      wr(`CGC_OFS_OSCCFG, 32'h0000_4530);
      #1;
      chk({26'h0, osc_cfg_o.remc_sel, osc_cfg_o.cac_sel}, 32'h25);
      chk({30'h0, osc_cfg_o.lpt_sel}, 32'h1);
      // codes one past the end are dropped
      wr(`CGC_OFS_OSCCFG, 32'h0000_5630);
      #1;
      chk({26'h0, osc_cfg_o.remc_sel, osc_cfg_o.cac_sel}, 32'h25);
   endtask : t_osccfg

   // stop detection with notify off, then on
   task automatic t_stop();
      wr(`CGC_OFS_SRCSEL, 32'h0000_0200);
      wait_src(5'h04);
      wr(`CGC_OFS_OSTD, 32'h0000_0001);
      main_osc_stop_i <= 1'b1;
      repeat (5) @(posedge ref_clk_i);
      #1;
      chk({30'h0, osc_stop_irq_o, pwm_oe_stop_o}, 32'h0);
      rd(`CGC_OFS_STATUS);
      chk({31'h0, rd_val[0]}, 32'h1);
      wait_src(5'h01);
      chk({27'h0, src_en_o}, 32'h1);
      // main source refused while the stop flag stands
      wr(`CGC_OFS_SRCSEL, 32'h0000_0200);
      rd(`CGC_OFS_SRCSEL);
      chk(rd_val, 32'h0000_0000);
      @(posedge ref_clk_i);
      main_osc_stop_i <= 1'b0;
      wr(`CGC_OFS_STATUS, 32'h1);
      wr(`CGC_OFS_OSTD, 32'h0000_0081);
      main_osc_stop_i <= 1'b1;
      // clear lands on the detect edge, three edges after the pin rose
      @(posedge ref_clk_i);
      wr(`CGC_OFS_STATUS, 32'h1);
      #1;
      chk({30'h0, osc_stop_irq_o, pwm_oe_stop_o}, 32'h3);
      @(posedge ref_clk_i);
      main_osc_stop_i <= 1'b0;
      wr(`CGC_OFS_STATUS, 32'h1);
      #1;
      chk({30'h0, osc_stop_irq_o, pwm_oe_stop_o}, 32'h0);
   endtask : t_stop

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      repeat (10) @(posedge ref_clk_i);
      arst_n_i <= 1'b1;
      #1;
      t_reset();
      t_divctl();
      t_source();
      t_pll();
      t_osccfg();
      t_stop();
      stop_test();
   end

endmodule : testbench
